// file: design/lmx_consts.svh
`ifndef LMX_CONSTS_SVH
`define LMX_CONSTS_SVH
// Clock rate and printed times
`define LMX_CLK_MHZ 50
`define LMX_ACT_FAST_NS 8000
`define LMX_ACT_SLOW_NS 16000
`define LMX_BLK_LONG_NS 1000
`define LMX_BLK_SHORT_NS 500
`define LMX_PHASE_NS 125
// Register offsets
`define LMX_OFS_TIMING 16'h0000
`define LMX_OFS_COMP 16'h0001
`define LMX_OFS_GHOST 16'h0002
`define LMX_OFS_STATUS 16'h0003
`define LMX_OFS_FILL 16'h0004
`define LMX_OFS_GPWM_A 16'h0010
`define LMX_OFS_GPWM_B 16'h0011
`define LMX_OFS_GPWM_C 16'h0012
`define LMX_PAGE_DUTY 8'h01
`define LMX_PAGE_GAIN 8'h02
`define LMX_PAGE_GROUP 8'h03
// Fields of timing_config_reg
`define LMX_F_FREQ 0
`define LMX_F_BLANK 1
`define LMX_F_PHASE 2
`define LMX_F_SHIFT 3
`define LMX_F_LINES_LO 4
`define LMX_F_LINES_HI 6
`define LMX_F_CHIPEN 7
`define LMX_F_MODE_LO 8
`define LMX_F_MODE_HI 9
`define LMX_F_PWM16 10
`define LMX_F_SHAMT_LO 12
`define LMX_F_SHAMT_HI 15
// Reset values
`define LMX_RST_TIMING 16'h0070
`define LMX_RST_COMP 6'h00
`define LMX_RST_GHOST 4'h0
`define LMX_RST_GPWM 8'hff
`define LMX_RST_DUTY 16'h0000
`define LMX_RST_GAIN 8'h80
`endif

// file: design/lmx_pkg.sv
package lmx_pkg;
    typedef enum {LMX_IDLE, LMX_BLANK, LMX_LEAD, LMX_ACTIVE, LMX_TAIL} lmx_state_e;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } lmx_bus_s;
    typedef struct packed {
        logic [7:0] lineOn;
        logic [7:0] lineClamp;
        logic [17:0] sinkOn;
        logic [17:0] sinkPrecharge;
    } lmx_drive_s;
endpackage

// file: design/lmx_scan_timing.sv
// What this block does
// R1 - 18 sinks, 8 line switches, 144 dots
// R2 - Scan lines ascending from 0, repeat
// R3 - Active line count programmable 1 to 8
// R4 - Line period: active, blank, two shifts
// R5 - Active time 8us or 16us by frequency
// R6 - Blank time 1us or 0.5us
// R7 - Phase shift 0 or 125ns; the block rounds this up to 7 core cycles, 140ns
// R8 - Sub-period is line period times lines
// R9 - Optional delayed sink turn-on
// R10 - Inactive lines discharged and clamped
// R11 - Off sinks precharged, adjustable strength
// R12 - Three compensation groups, own strength
// R13 - Compensation group is sink index mod three
// R14 - Per-dot PWM, 8 or 16 bit; the 16-bit mode compares only the high byte of the duty
// R15 - Dots map onto 8-bit group PWM
// R16 - Per-dot 8-bit current gain
// R17 - Full refresh and partial update
// R18 - Timing derived from the core oscillator
// R19 - Deghost settings gated by chip enable
// R20 - Sinks off in blank, on only active
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "lmx_consts.svh"
module lmx_scan_timing #(
    parameter int NUM_LINES = 8,
    parameter int NUM_SINKS = 18
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire lmx_pkg::lmx_bus_s bus,
    output logic [15:0] rdata,
    output lmx_pkg::lmx_drive_s drive,
    output logic [NUM_SINKS*8-1:0] sinkGain,
    output logic [NUM_SINKS*2-1:0] compLevel,
    output logic [1:0] upClampLevel,
    output logic [1:0] downPrechargeLevel,
    output logic subPeriodStart
);
    import lmx_pkg::*;

    localparam int DOTS = NUM_LINES * NUM_SINKS;
    // Cycle counts; least times round up at the core rate
    localparam int ACT_FAST = (`LMX_ACT_FAST_NS * `LMX_CLK_MHZ + 999) / 1000; // R18
    localparam int ACT_SLOW = (`LMX_ACT_SLOW_NS * `LMX_CLK_MHZ + 999) / 1000;
    localparam int BLK_LONG = (`LMX_BLK_LONG_NS * `LMX_CLK_MHZ + 999) / 1000;
    localparam int BLK_SHORT = (`LMX_BLK_SHORT_NS * `LMX_CLK_MHZ + 999) / 1000;
    localparam int PHASE_CYC = (`LMX_PHASE_NS * `LMX_CLK_MHZ + 999) / 1000;

    // The drive struct and line index are fixed at 8 lines by 18 sinks
    initial begin
        if (NUM_LINES != 8 || NUM_SINKS != 18) begin
            $error("lmx_scan_timing supports 8 lines and 18 sinks only");
        end
    end

    // Scale a dot duty by its group duty, full scale stays full scale
    function automatic logic [7:0] scaleDuty(input logic [7:0] d, input logic [7:0] g);
        logic [15:0] p;
        p = d * g + {8'h00, d};
        return p[15:8];
    endfunction

    // Compensation group of a sink
    function automatic int compGroup(input int s);
        return s % 3; // R13
    endfunction

    logic [15:0] timingCfg;
    logic [5:0] compCfg;
    logic [3:0] ghostShadow;
    logic [3:0] ghostActive;
    logic [7:0] gpwm [3];
    logic [15:0] dutyMem [DOTS];
    logic [7:0] gainMem [DOTS];
    logic [1:0] groupMem [DOTS];
    lmx_state_e state;
    logic [9:0] phaseCnt;
    logic [2:0] curLine;
    logic chipEnLast;

    logic chipEn;
    logic modeImmediate;
    logic [2:0] lastLine;
    logic [9:0] activeLen;
    logic [9:0] blankLen;
    logic [7:0] pageIdx;
    logic idxOk;
    assign chipEn = timingCfg[`LMX_F_CHIPEN];
    assign modeImmediate = timingCfg[`LMX_F_MODE_HI:`LMX_F_MODE_LO] == 2'b00;
    assign lastLine = timingCfg[`LMX_F_LINES_HI:`LMX_F_LINES_LO]; // R3
    assign activeLen = timingCfg[`LMX_F_FREQ] ? 10'(ACT_SLOW) : 10'(ACT_FAST); // R5
    assign blankLen = timingCfg[`LMX_F_BLANK] ? 10'(BLK_SHORT) : 10'(BLK_LONG); // R6
    assign pageIdx = bus.addr[7:0];
    assign idxOk = pageIdx < 8'(DOTS);

    // Configuration registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            timingCfg <= `LMX_RST_TIMING;
            compCfg <= `LMX_RST_COMP;
            for (int g = 0; g < 3; g++) begin
                gpwm[g] <= `LMX_RST_GPWM;
            end
        end else if (bus.wr) begin
            case (bus.addr)
                `LMX_OFS_TIMING: timingCfg <= bus.wdata;
                `LMX_OFS_COMP: compCfg <= bus.wdata[5:0]; // R12
                `LMX_OFS_GPWM_A: gpwm[0] <= bus.wdata[7:0]; // R15
                `LMX_OFS_GPWM_B: gpwm[1] <= bus.wdata[7:0];
                `LMX_OFS_GPWM_C: gpwm[2] <= bus.wdata[7:0];
                default: ;
            endcase
        end
    end

    // Deghost shadow: refused in modes 2 to 4 while the chip is enabled
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ghostShadow <= `LMX_RST_GHOST;
        end else if (bus.wr && bus.addr == `LMX_OFS_GHOST && (modeImmediate || !chipEn)) begin
            ghostShadow <= bus.wdata[3:0]; // R19
        end
    end

    // Deghost settings apply at once in mode 1, else on chip enable rising
    always_ff @(posedge core_clk) begin
        if (rst) begin
            chipEnLast <= 1'b0;
            ghostActive <= `LMX_RST_GHOST;
        end else begin
            chipEnLast <= chipEn;
            if (modeImmediate || (chipEn && !chipEnLast)) begin
                ghostActive <= ghostShadow; // R19
            end
        end
    end

    // Dot memory: single writes are partial updates, fill rewrites the duty of every dot
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < DOTS; i++) begin
                dutyMem[i] <= `LMX_RST_DUTY;
                gainMem[i] <= `LMX_RST_GAIN;
                groupMem[i] <= 2'b00;
            end
        end else if (bus.wr) begin
            if (bus.addr == `LMX_OFS_FILL) begin
                for (int i = 0; i < DOTS; i++) begin
                    dutyMem[i] <= bus.wdata; // R17
                end
            end else if (idxOk) begin
                case (bus.addr[15:8])
                    `LMX_PAGE_DUTY: dutyMem[pageIdx] <= bus.wdata; // R14
                    `LMX_PAGE_GAIN: gainMem[pageIdx] <= bus.wdata[7:0]; // R16
                    `LMX_PAGE_GROUP: groupMem[pageIdx] <= bus.wdata[1:0]; // R15
                    default: ;
                endcase
            end
        end
    end

    // Read data stands one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else if (bus.rd) begin
            rdata <= 16'h0000;
            case (bus.addr)
                `LMX_OFS_TIMING: rdata <= timingCfg;
                `LMX_OFS_COMP: rdata <= {10'h000, compCfg};
                `LMX_OFS_GHOST: rdata <= {8'h00, ghostActive, ghostShadow};
                `LMX_OFS_STATUS: rdata <= {9'h000, 3'(state), 1'b0, curLine};
                `LMX_OFS_GPWM_A: rdata <= {8'h00, gpwm[0]};
                `LMX_OFS_GPWM_B: rdata <= {8'h00, gpwm[1]};
                `LMX_OFS_GPWM_C: rdata <= {8'h00, gpwm[2]};
                default: begin
                    if (idxOk && bus.addr[15:8] == `LMX_PAGE_DUTY) begin
                        rdata <= dutyMem[pageIdx];
                    end else if (idxOk && bus.addr[15:8] == `LMX_PAGE_GAIN) begin
                        rdata <= {8'h00, gainMem[pageIdx]};
                    end else if (idxOk && bus.addr[15:8] == `LMX_PAGE_GROUP) begin
                        rdata <= {14'h0000, groupMem[pageIdx]};
                    end
                end
            endcase
        end
    end

    // Line sequencer: blank, lead shift, active, tail shift, next line
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= LMX_IDLE;
            phaseCnt <= 10'h000;
            curLine <= 3'h0;
        end else if (!chipEn) begin
            state <= LMX_IDLE;
            phaseCnt <= 10'h000;
            curLine <= 3'h0;
        end else begin
            phaseCnt <= phaseCnt + 10'h001;
            case (state)
                LMX_IDLE: begin
                    state <= LMX_BLANK;
                    phaseCnt <= 10'h000;
                end
                LMX_BLANK: begin
                    if (phaseCnt == blankLen - 10'h001) begin // R4
                        phaseCnt <= 10'h000;
                        state <= timingCfg[`LMX_F_PHASE] ? LMX_LEAD : LMX_ACTIVE; // R7
                    end
                end
                LMX_LEAD: begin
                    if (phaseCnt == 10'(PHASE_CYC - 1)) begin // R7
                        phaseCnt <= 10'h000;
                        state <= LMX_ACTIVE;
                    end
                end
                LMX_ACTIVE: begin
                    if (phaseCnt == activeLen - 10'h001) begin // R4
                        phaseCnt <= 10'h000;
                        state <= timingCfg[`LMX_F_PHASE] ? LMX_TAIL : LMX_BLANK;
                        if (!timingCfg[`LMX_F_PHASE]) begin
                            curLine <= (curLine >= lastLine) ? 3'h0 : curLine + 3'h1; // R2 R8
                        end
                    end
                end
                LMX_TAIL: begin
                    if (phaseCnt == 10'(PHASE_CYC - 1)) begin
                        phaseCnt <= 10'h000;
                        state <= LMX_BLANK;
                        curLine <= (curLine >= lastLine) ? 3'h0 : curLine + 3'h1; // R2 R8
                    end
                end
                default: state <= LMX_IDLE;
            endcase
        end
    end

    // Sink decisions for the selected line, registered below
    logic [NUM_SINKS-1:0] next_sinkOn;
    logic [NUM_SINKS*8-1:0] next_sinkGain;
    logic [7:0] pwmStep;
    logic shiftDone;
    // Slow rate halves the step rate so both periods span 200 steps
    assign pwmStep = timingCfg[`LMX_F_FREQ] ? 8'(phaseCnt >> 2) : 8'(phaseCnt >> 1);
    assign shiftDone = !timingCfg[`LMX_F_SHIFT] ||
        phaseCnt >= {6'h00, timingCfg[`LMX_F_SHAMT_HI:`LMX_F_SHAMT_LO]}; // R9
    always_comb begin
        int idx;
        logic [7:0] duty;
        idx = 0;
        duty = 8'h00;
        next_sinkOn = '0;
        next_sinkGain = '0;
        for (int s = 0; s < NUM_SINKS; s++) begin
            idx = int'(curLine) * NUM_SINKS + s; // R1
            duty = timingCfg[`LMX_F_PWM16] ? dutyMem[idx][15:8] : dutyMem[idx][7:0]; // R14
            if (groupMem[idx] != 2'b00) begin
                duty = scaleDuty(duty, gpwm[groupMem[idx] - 2'b01]); // R15
            end
            next_sinkOn[s] = state == LMX_ACTIVE && shiftDone && duty > pwmStep; // R20
            next_sinkGain[s*8 +: 8] = gainMem[idx]; // R16
        end
    end

    // Drive outputs come from flops so sinks and lines switch together
    always_ff @(posedge core_clk) begin
        if (rst) begin
            drive <= '0;
            sinkGain <= '0;
        end else begin
            drive.sinkOn <= next_sinkOn; // R20
            drive.sinkPrecharge <= chipEn ? ~next_sinkOn : '0; // R11
            drive.lineOn <= '0;
            drive.lineClamp <= chipEn ? 8'hff : 8'h00; // R10
            if (state == LMX_LEAD || state == LMX_ACTIVE || state == LMX_TAIL) begin
                drive.lineOn[curLine] <= 1'b1;
                drive.lineClamp[curLine] <= 1'b0; // R10
            end
            sinkGain <= next_sinkGain;
        end
    end

    // Compensation strength per sink by its group
    always_ff @(posedge core_clk) begin
        if (rst) begin
            compLevel <= '0;
        end else begin
            for (int s = 0; s < NUM_SINKS; s++) begin
                compLevel[s*2 +: 2] <= compCfg[compGroup(s)*2 +: 2]; // R12 R13
            end
        end
    end

    // Deghost strengths and a pulse at each sub-period start
    always_ff @(posedge core_clk) begin
        if (rst) begin
            upClampLevel <= 2'b00;
            downPrechargeLevel <= 2'b00;
            subPeriodStart <= 1'b0;
        end else begin
            upClampLevel <= ghostActive[1:0]; // R10
            downPrechargeLevel <= ghostActive[3:2]; // R11
            subPeriodStart <= state == LMX_BLANK && phaseCnt == 10'h000 && curLine == 3'h0; // R8
        end
    end
endmodule // lmx_scan_timing

// file: sim/lmx_scan_timing_sva.sv
`timescale 1ns/10ps
module lmx_scan_timing_sva #(
    parameter int NUM_LINES = 8,
    parameter int NUM_SINKS = 18
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire lmx_pkg::lmx_bus_s bus,
    input wire logic [15:0] rdata,
    input wire lmx_pkg::lmx_drive_s drive,
    input wire logic [NUM_SINKS*8-1:0] sinkGain,
    input wire logic [NUM_SINKS*2-1:0] compLevel,
    input wire logic [1:0] upClampLevel,
    input wire logic [1:0] downPrechargeLevel,
    input wire logic subPeriodStart
);
    import lmx_pkg::*;
    logic [15:0] cfg, onRun, offRun, spCnt;
    logic [7:0] lastOn;
    logic seenFall, spValid;
    int ph, lead, onLen, lineLen;
    wire anyOn = |drive.lineOn;
    wire cfgWr = bus.wr && bus.addr == 16'h0000;
    wire [7:0] nextOn = (!seenFall || lastOn[cfg[6:4]]) ? 8'h01 : {lastOn[6:0], 1'b0};
    // Expected lengths follow the shadowed timing word
    assign ph = cfg[2] ? 7 : 0;
    assign lead = ph + (cfg[3] ? int'(cfg[15:12]) : 0);
    assign onLen = (cfg[0] ? 800 : 400) + 2 * ph;
    assign lineLen = onLen + (cfg[1] ? 25 : 50);
    // Shadow of the timing word and run lengths of the line switches
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg <= 16'h0070;
            {onRun, offRun, spCnt, lastOn} <= '0;
        end else begin
            if (cfgWr) begin
                cfg <= bus.wdata;
            end
            onRun <= anyOn ? onRun + 16'h0001 : 16'h0000;
            offRun <= anyOn ? 16'h0000 : offRun + 16'h0001;
            spCnt <= subPeriodStart ? 16'h0001 : spCnt + 16'h0001;
            lastOn <= anyOn ? drive.lineOn : lastOn;
        end
    end
    // A timing write restarts the bookkeeping, since the lengths change under it
    always_ff @(posedge core_clk) begin
        if (rst || cfgWr) begin
            {seenFall, spValid} <= 2'b00;
        end else begin
            seenFall <= seenFall | (!anyOn && onRun != 16'h0000);
            spValid <= spValid | subPeriodStart;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_onehot; $onehot0(drive.lineOn); endproperty
    a_onehot: assert property (p_onehot) else $error("two lines on");
    property p_order; $rose(anyOn) |-> drive.lineOn == nextOn; endproperty
    a_order: assert property (p_order) else $error("line order");
    property p_linelen; $fell(anyOn) && cfg[7] |-> onRun == onLen; endproperty
    a_linelen: assert property (p_linelen) else $error("line on length");
    property p_blank; $rose(anyOn) && seenFall |-> offRun == (cfg[1] ? 25 : 50); endproperty
    a_blank: assert property (p_blank) else $error("blank length");
    property p_sinkwin; |drive.sinkOn |-> anyOn && onRun >= lead && onRun < onLen - ph; endproperty
    a_sinkwin: assert property (p_sinkwin) else $error("sink outside window");
    property p_prechg; |drive.sinkPrecharge |-> drive.sinkPrecharge == ~drive.sinkOn; endproperty
    a_prechg: assert property (p_prechg) else $error("precharge");
    property p_clamp; anyOn && cfg[7] |-> drive.lineClamp == ~drive.lineOn; endproperty
    a_clamp: assert property (p_clamp) else $error("line clamp");
    property p_group; compLevel[NUM_SINKS*2-1:6] == compLevel[NUM_SINKS*2-7:0]; endproperty
    a_group: assert property (p_group) else $error("comp group");
    property p_subper;
        subPeriodStart && spValid && cfg[7] |-> spCnt == (int'(cfg[6:4]) + 1) * lineLen;
    endproperty
    a_subper: assert property (p_subper) else $error("sub-period length");
    property p_ghold;
        bus.wr && bus.addr == 16'h0002 && cfg[9:8] != 2'b00 && cfg[7]
            |=> $stable({downPrechargeLevel, upClampLevel}) [*3];
    endproperty
    a_ghold: assert property (p_ghold) else $error("ghost changed");
    c_sub: cover property (subPeriodStart && spValid);
    c_shift: cover property (|drive.sinkOn && cfg[3] && cfg[15:12] != 4'h0);
    c_ghold: cover property (bus.wr && bus.addr == 16'h0002 && cfg[9:8] != 2'b00 && cfg[7]);
endmodule // lmx_scan_timing_sva
bind lmx_scan_timing lmx_scan_timing_sva #(.NUM_LINES(NUM_LINES), .NUM_SINKS(NUM_SINKS)) u_sva (
    .core_clk(core_clk), .rst(rst), .bus(bus), .rdata(rdata), .drive(drive),
    .sinkGain(sinkGain), .compLevel(compLevel), .upClampLevel(upClampLevel),
    .downPrechargeLevel(downPrechargeLevel), .subPeriodStart(subPeriodStart));

// file: sim/lmx_led_matrix.sv
`timescale 1ns/10ps
module lmx_led_matrix (
    input wire logic core_clk,
    input wire logic clear,
    input wire lmx_pkg::lmx_drive_s drive,
    output logic [7:0] lineSeen,
    output logic [143:0] dotLit
);
    import lmx_pkg::*;
    // A dot lights only where its line switch and its sink conduct together
    always_ff @(posedge core_clk) begin
        if (clear) begin
            lineSeen <= 8'h00;
            dotLit <= '0;
        end else begin
            lineSeen <= lineSeen | drive.lineOn;
            for (int l = 0; l < 8; l++) begin
                if (drive.lineOn[l]) begin
                    dotLit[l*18 +: 18] <= dotLit[l*18 +: 18] | drive.sinkOn;
                end
            end
        end
    end
endmodule // lmx_led_matrix

// file: sim/testbench.sv
`timescale 1ns/10ps
module testbench;
    import lmx_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, clear = 1'b0, rdPend = 1'b0, subPeriodStart;
    lmx_bus_s bus = '0;
    lmx_drive_s drive;
    logic [15:0] rdata, cfgWord, v, expQ[$];
    logic [143:0] sinkGain, dotLit;
    logic [35:0] compLevel;
    logic [1:0] upClampLevel, downPrechargeLevel;
    logic [7:0] lineSeen;
    int bad_count = 0, samples_checked = 0, seed = 67238, n, w;
    always #10 core_clk = ~core_clk;
    lmx_scan_timing u_lmx_scan_timing (.core_clk(core_clk), .rst(rst), .bus(bus), .rdata(rdata),
        .drive(drive), .sinkGain(sinkGain), .compLevel(compLevel), .upClampLevel(upClampLevel),
        .downPrechargeLevel(downPrechargeLevel), .subPeriodStart(subPeriodStart));
    lmx_led_matrix u_lmx_led_matrix (.core_clk(core_clk), .clear(clear), .drive(drive),
        .lineSeen(lineSeen), .dotLit(dotLit));
    task automatic check(input string what, input logic [143:0] seen, input logic [143:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One bus cycle; for reads d is the expected answer, noted for the monitor
    task automatic op(input logic r, input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        bus <= '{a, d, !r, r};
        if (r) expQ.push_back(d);
        @(posedge core_clk);
        bus <= '{a, d, 1'b0, 1'b0};
    endtask
    task automatic setc(input logic [15:0] c);
        cfgWord = c;
        op(0, 16'h0000, c);
    endtask
    // Stop first so that no setting changes under a running line
    task automatic run(input logic [15:0] c);
        setc(cfgWord & 16'hff7f);
        setc(c & 16'hff7f);
        setc(c | 16'h0080);
    endtask
    task automatic waitp();
        for (w = 0; subPeriodStart !== 1'b1 && w < 20000; w++) @(posedge core_clk);
        if (w == 20000) check("pulse", 0, 1);
        @(posedge core_clk);
    endtask
    // Collect exactly one whole sub-period in the matrix model
    task automatic sweep();
        waitp();
        clear <= 1'b1;
        @(posedge core_clk);
        clear <= 1'b0;
        waitp();
    endtask
    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Read answers arrive one cycle late and are matched in issue order
    always @(posedge core_clk) begin
        if (rdPend) check("rdata", rdata, expQ.pop_front());
        rdPend <= bus.rd;
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        cfgWord = 16'h0070;
        op(1, 16'h0000, 16'h0070);
        op(1, 16'h0005, 16'h0000);
        op(0, 16'h0004, 16'hffff);
        for (int i = 0; i < 8; i++) begin
            n = 1 + $unsigned($random(seed)) % (i[0] ? 3 : 8);
            run(16'(i + (n - 1) * 16));
            sweep();
            check("lines", lineSeen, (144'h1 << n) - 1);
            check("dots", dotLit, (144'h1 << (18 * n)) - 1);
            $display("done timing %0d", i);
        end
        v = 16'($random(seed));
        run({v[15:12] | 4'h1, 12'h01c});
        op(0, 16'h0100, 16'h0000);
        op(0, 16'h0205, v & 16'h00ff);
        op(1, 16'h0205, v & 16'h00ff);
        sweep();
        check("partial", dotLit, (144'h1 << 36) - 2);
        // Gains reach the sinks while line 0 is selected; dot 5 holds the written gain
        for (w = 0; drive.lineOn[0] !== 1'b1 && w < 200; w++) @(posedge core_clk);
        check("gain", sinkGain,
            ({18{8'h80}} & ~(144'hff << 40)) | (144'(v[7:0]) << 40));
        op(0, 16'h0001, v);
        op(0, 16'h0002, v);
        repeat (3) @(posedge core_clk);
        check("comp", compLevel, {6{v[5:0]}});
        check("ghost", {downPrechargeLevel, upClampLevel}, v[3:0]);
        $display("done shift comp");
        // Wide duties use the high byte; a zero group duty darkens its member
        op(0, 16'h0102, 16'h00ff);
        op(0, 16'h0301, 16'h0001);
        op(0, 16'h0010, 16'h0000);
        op(1, 16'h0010, 16'h0000);
        run(16'h0410);
        sweep();
        check("group", dotLit, (144'h1 << 36) - 8);
        $display("done group");
        run(16'h0110);
        op(0, 16'h0002, ~v);
        repeat (3) @(posedge core_clk);
        check("held", {downPrechargeLevel, upClampLevel}, v[3:0]);
        v = ~v;
        setc(16'h0110);
        op(0, 16'h0002, v);
        check("clamp", drive.lineClamp, 0);
        op(1, 16'h0003, 16'h0000);
        setc(16'h0190);
        repeat (3) @(posedge core_clk);
        check("applied", {downPrechargeLevel, upClampLevel}, v[3:0]);
        $display("done ghost");
        stop_test();
    end
    initial begin
        repeat (90000) @(posedge core_clk);
        check("watchdog", 0, 1);
        stop_test();
    end
endmodule // testbench
